// >>> rsi_pkg.sv
// Shared constants, types and register map for the repeater status indicator logic.
package rsi_pkg;

    // Clock rate and blink timing.
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned BLINK_HALF_MS    = 500;
    localparam int unsigned BLINK_HALF_CYC   = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned BLINK_CNT_W      = 23;

    // APB register byte addresses.
    localparam logic [7:0]  ADDR_CTRL        = 8'h00;
    localparam logic [7:0]  ADDR_STATUS      = 8'h04;
    localparam logic [7:0]  ADDR_INDICATORS  = 8'h08;

    // Control register field positions and reset value.
    localparam int unsigned CTRL_REDUN_BIT   = 0;
    localparam int unsigned CTRL_SUP2_BIT    = 1;
    localparam int unsigned CTRL_SUP3_BIT    = 2;
    localparam logic [2:0]  CTRL_RESET       = 3'h0;

    // Status register field positions.
    localparam int unsigned STAT_INPUTS_LSB  = 0;
    localparam int unsigned STAT_FAULT_BIT   = 16;
    localparam int unsigned STAT_RED_BIT     = 17;
    localparam int unsigned STAT_REDPORT_BIT = 18;

    // Indicator register field positions, two bits each, plus the single blink flag bit.
    localparam int unsigned IND_SYS_LSB      = 0;
    localparam int unsigned IND_SUP1_LSB     = 2;
    localparam int unsigned IND_SUP2_LSB     = 4;
    localparam int unsigned IND_RING_LSB     = 6;
    localparam int unsigned IND_PORT1_LSB    = 8;
    localparam int unsigned IND_PORT2_LSB    = 10;
    localparam int unsigned IND_PORT3_LSB    = 12;
    localparam int unsigned IND_BLINK_BIT    = 14;

    // Colour code driven to each indicator.
    typedef enum logic [1:0] {
        LED_OFF    = 2'b00,
        LED_GREEN  = 2'b01,
        LED_YELLOW = 2'b10,
        LED_RED    = 2'b11
    } rsi_led_t;

    // Monitored inputs after synchronisation.
    typedef struct packed {
        logic feed_one_ok;
        logic feed_two_ok;
        logic internal_err;
        logic port1_data_ch1;
        logic port1_data_ch2;
        logic port2_power_ok;
        logic port2_data;
        logic port3_power_ok;
        logic port3_data;
        logic ring_fault;
        logic ring_conflict;
    } rsi_inputs_t;

    localparam int unsigned INPUTS_W         = $bits(rsi_inputs_t);

    // Installer switches held in the control register.
    typedef struct packed {
        logic port3_report_suppress_switch;
        logic port2_report_suppress_switch;
        logic redundancy_enable_switch;
    } rsi_ctrl_t;

endpackage

// >>> rsi_status.sv
// Top module: indicator decoding, fault relay and APB register access.
`timescale 1ns/100ps
module rsi_status #(
    parameter int unsigned BLINK_HALF = rsi_pkg::BLINK_HALF_CYC
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic        FEED_ONE_OK,
    input  wire logic        FEED_TWO_OK,
    input  wire logic        INTERNAL_ERR,
    input  wire logic        PORT1_DATA_CH1,
    input  wire logic        PORT1_DATA_CH2,
    input  wire logic        PORT2_POWER_OK,
    input  wire logic        PORT2_DATA,
    input  wire logic        PORT3_POWER_OK,
    input  wire logic        PORT3_DATA,
    input  wire logic        RING_FAULT,
    input  wire logic        RING_CONFLICT,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic      [1:0]  SYSTEM_INDICATOR,
    output logic      [1:0]  SUPPLY_ONE_INDICATOR,
    output logic      [1:0]  SUPPLY_TWO_INDICATOR,
    output logic      [1:0]  RING_MANAGER_INDICATOR,
    output logic      [1:0]  PORT1_ACTIVITY_INDICATOR,
    output logic      [1:0]  PORT2_ACTIVITY_INDICATOR,
    output logic      [1:0]  PORT3_ACTIVITY_INDICATOR,
    output logic             REDUNDANT_PORT_ACTIVE,
    output logic             RELAY_CLOSED
);

    // Two-stage synchroniser for all monitored pin inputs; only stage two feeds logic.
    rsi_pkg::rsi_inputs_t  pins_w;
    rsi_pkg::rsi_inputs_t  sync1_ff;
    rsi_pkg::rsi_inputs_t  in_ff;

    assign pins_w = '{feed_one_ok:    FEED_ONE_OK,
                      feed_two_ok:    FEED_TWO_OK,
                      internal_err:   INTERNAL_ERR,
                      port1_data_ch1: PORT1_DATA_CH1,
                      port1_data_ch2: PORT1_DATA_CH2,
                      port2_power_ok: PORT2_POWER_OK,
                      port2_data:     PORT2_DATA,
                      port3_power_ok: PORT3_POWER_OK,
                      port3_data:     PORT3_DATA,
                      ring_fault:     RING_FAULT,
                      ring_conflict:  RING_CONFLICT};

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            sync1_ff <= '0;
            in_ff    <= '0;
        end else begin
            sync1_ff <= pins_w;
            in_ff    <= sync1_ff;
        end
    end

    // Control register, written by software in place of the DIL switches.
    rsi_pkg::rsi_ctrl_t    ctrl_ff;
    rsi_pkg::rsi_ctrl_t    nxt_ctrl;

    // Blink phase for the ring indicator; counts only while a conflict is shown,
    // so the first blink period always starts with the lamp lit.
    localparam int unsigned          BLINK_CNT_W = rsi_pkg::BLINK_CNT_W;
    logic [rsi_pkg::BLINK_CNT_W-1:0] blink_cnt_ff;
    logic [rsi_pkg::BLINK_CNT_W-1:0] nxt_blink_cnt;
    logic                            blink_on_ff;
    logic                            nxt_blink_on;
    logic                            blink_wrap_w;

    // Condition decode.
    logic      feed_one_low_w;
    logic      feed_two_low_w;
    logic      one_feed_w;
    logic      power_lost_w;
    logic      port2_missing_w;
    logic      port3_missing_w;
    logic      port2_report_w;
    logic      port3_report_w;
    logic      ring_blink_w;
    logic      fault_w;
    logic      red_w;

    assign feed_one_low_w  = !in_ff.feed_one_ok;
    assign feed_two_low_w  = !in_ff.feed_two_ok;
    assign one_feed_w      = in_ff.feed_one_ok ^ in_ff.feed_two_ok;
    assign power_lost_w    = feed_one_low_w && feed_two_low_w;
    assign port2_missing_w = !in_ff.port2_power_ok && !in_ff.port2_data;
    assign port3_missing_w = !in_ff.port3_power_ok && !in_ff.port3_data;
    assign port2_report_w  = port2_missing_w
                             && !ctrl_ff.port2_report_suppress_switch;
    assign port3_report_w  = port3_missing_w
                             && !ctrl_ff.port3_report_suppress_switch;
    assign ring_blink_w    = ctrl_ff.redundancy_enable_switch
                             && in_ff.ring_conflict;

    // One OR for the relay; red drops the total power loss and internal error terms,
    // where the real lamp would be dark anyway.
    assign fault_w = one_feed_w || feed_one_low_w || feed_two_low_w
                     || port2_report_w || port3_report_w
                     || ring_blink_w || in_ff.internal_err;
    assign red_w   = one_feed_w || port2_report_w || port3_report_w
                     || ring_blink_w;

    // Indicator colour decode.
    rsi_pkg::rsi_led_t sys_w;
    rsi_pkg::rsi_led_t sup1_w;
    rsi_pkg::rsi_led_t sup2_w;
    rsi_pkg::rsi_led_t ring_w;
    rsi_pkg::rsi_led_t port1_w;
    rsi_pkg::rsi_led_t port2_w;
    rsi_pkg::rsi_led_t port3_w;
    logic              redport_w;

    assign sys_w   = (power_lost_w || in_ff.internal_err) ? rsi_pkg::LED_OFF :
                     red_w ? rsi_pkg::LED_RED : rsi_pkg::LED_GREEN;
    assign sup1_w  = in_ff.feed_one_ok ? rsi_pkg::LED_GREEN : rsi_pkg::LED_OFF;
    assign sup2_w  = in_ff.feed_two_ok ? rsi_pkg::LED_GREEN : rsi_pkg::LED_OFF;
    assign ring_w  = !ctrl_ff.redundancy_enable_switch ? rsi_pkg::LED_OFF :
                     in_ff.ring_conflict ?
                         (blink_on_ff ? rsi_pkg::LED_YELLOW : rsi_pkg::LED_OFF) :
                     in_ff.ring_fault ? rsi_pkg::LED_YELLOW :
                     rsi_pkg::LED_GREEN;
    assign redport_w = ctrl_ff.redundancy_enable_switch && in_ff.ring_fault
                       && !in_ff.ring_conflict;
    assign port1_w = (in_ff.port1_data_ch1 || in_ff.port1_data_ch2) ?
                     rsi_pkg::LED_YELLOW : rsi_pkg::LED_OFF;
    // Data traffic is shown in preference to the power-good green; one decode
    // serves both optical ports so they can never drift apart.
    function automatic rsi_pkg::rsi_led_t port_lamp(input logic data, input logic power_ok);
        port_lamp = data ? rsi_pkg::LED_YELLOW :
                    power_ok ? rsi_pkg::LED_GREEN : rsi_pkg::LED_OFF;
    endfunction

    assign port2_w = port_lamp(in_ff.port2_data, in_ff.port2_power_ok);
    assign port3_w = port_lamp(in_ff.port3_data, in_ff.port3_power_ok);

    // Blink counter next state.
    assign blink_wrap_w  = (blink_cnt_ff == BLINK_CNT_W'(BLINK_HALF - 1));
    assign nxt_blink_cnt = (!ring_blink_w || blink_wrap_w) ? '0 :
                           blink_cnt_ff + 1'b1;
    assign nxt_blink_on  = !ring_blink_w ? 1'b1 :
                           blink_wrap_w ? !blink_on_ff : blink_on_ff;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            blink_cnt_ff <= '0;
            blink_on_ff  <= 1'b1;
        end else begin
            blink_cnt_ff <= nxt_blink_cnt;
            blink_on_ff  <= nxt_blink_on;
        end
    end

    // Output registers; during reset all lamps are dark and the relay is open.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            SYSTEM_INDICATOR         <= rsi_pkg::LED_OFF;
            SUPPLY_ONE_INDICATOR     <= rsi_pkg::LED_OFF;
            SUPPLY_TWO_INDICATOR     <= rsi_pkg::LED_OFF;
            RING_MANAGER_INDICATOR   <= rsi_pkg::LED_OFF;
            PORT1_ACTIVITY_INDICATOR <= rsi_pkg::LED_OFF;
            PORT2_ACTIVITY_INDICATOR <= rsi_pkg::LED_OFF;
            PORT3_ACTIVITY_INDICATOR <= rsi_pkg::LED_OFF;
            REDUNDANT_PORT_ACTIVE    <= 1'b0;
            RELAY_CLOSED             <= 1'b0;
        end else begin
            SYSTEM_INDICATOR         <= sys_w;
            SUPPLY_ONE_INDICATOR     <= sup1_w;
            SUPPLY_TWO_INDICATOR     <= sup2_w;
            RING_MANAGER_INDICATOR   <= ring_w;
            PORT1_ACTIVITY_INDICATOR <= port1_w;
            PORT2_ACTIVITY_INDICATOR <= port2_w;
            PORT3_ACTIVITY_INDICATOR <= port3_w;
            REDUNDANT_PORT_ACTIVE    <= redport_w;
            RELAY_CLOSED             <= !fault_w;
        end
    end

    // APB decode. The answer is prepared in the setup cycle, so every access
    // completes in its first access cycle with registered read data.
    logic        setup_w;
    logic        access_w;
    logic        hit_ctrl_w;
    logic        hit_stat_w;
    logic        hit_ind_w;
    logic        mapped_w;
    logic [31:0] rd_mux_w;
    logic [31:0] stat_w;
    logic [31:0] ind_w;

    assign setup_w    = PSEL && !PENABLE;
    assign access_w   = PSEL && PENABLE && PREADY;
    assign hit_ctrl_w = (PADDR == rsi_pkg::ADDR_CTRL);
    assign hit_stat_w = (PADDR == rsi_pkg::ADDR_STATUS);
    assign hit_ind_w  = (PADDR == rsi_pkg::ADDR_INDICATORS);
    assign mapped_w   = hit_ctrl_w || hit_stat_w || hit_ind_w;

    assign stat_w = 32'(in_ff) << rsi_pkg::STAT_INPUTS_LSB
                  | 32'(!RELAY_CLOSED) << rsi_pkg::STAT_FAULT_BIT
                  | 32'(SYSTEM_INDICATOR == rsi_pkg::LED_RED) << rsi_pkg::STAT_RED_BIT
                  | 32'(REDUNDANT_PORT_ACTIVE) << rsi_pkg::STAT_REDPORT_BIT;
    assign ind_w  = 32'(SYSTEM_INDICATOR)         << rsi_pkg::IND_SYS_LSB
                  | 32'(SUPPLY_ONE_INDICATOR)     << rsi_pkg::IND_SUP1_LSB
                  | 32'(SUPPLY_TWO_INDICATOR)     << rsi_pkg::IND_SUP2_LSB
                  | 32'(RING_MANAGER_INDICATOR)   << rsi_pkg::IND_RING_LSB
                  | 32'(PORT1_ACTIVITY_INDICATOR) << rsi_pkg::IND_PORT1_LSB
                  | 32'(PORT2_ACTIVITY_INDICATOR) << rsi_pkg::IND_PORT2_LSB
                  | 32'(PORT3_ACTIVITY_INDICATOR) << rsi_pkg::IND_PORT3_LSB
                  | 32'(ring_blink_w)             << rsi_pkg::IND_BLINK_BIT;
    assign rd_mux_w = hit_ctrl_w ? 32'(ctrl_ff) :
                      hit_stat_w ? stat_w :
                      hit_ind_w  ? ind_w : 32'h0000_0000;

    // Writes land only at the completing edge; the read-only words ignore them.
    assign nxt_ctrl = (access_w && PWRITE && hit_ctrl_w) ?
                      rsi_pkg::rsi_ctrl_t'(PWDATA[2:0]) : ctrl_ff;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ctrl_ff <= rsi_pkg::rsi_ctrl_t'(rsi_pkg::CTRL_RESET);
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            PREADY  <= setup_w;
            PSLVERR <= setup_w && !mapped_w;
            PRDATA  <= setup_w ? rd_mux_w : 32'h0000_0000;
        end
    end

    // Checks on the decode against the synchronised inputs one edge back, except a_healthy_green and a_apb_ready.
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    // An internal error or total power loss darkens the system lamp, so the
    // red checks leave those cases out.
    a_healthy_green: assert property ($rose(RELAY_CLOSED)
        |-> SYSTEM_INDICATOR == rsi_pkg::LED_GREEN)
        else $error("Relay closed while system indicator not green.");
    a_single_feed: assert property (one_feed_w && !in_ff.internal_err
        |=> SYSTEM_INDICATOR == rsi_pkg::LED_RED && !RELAY_CLOSED)
        else $error("Single supply feed did not give red and open relay.");
    a_port_missing: assert property ((port2_report_w || port3_report_w)
        && !in_ff.internal_err && !power_lost_w
        |=> SYSTEM_INDICATOR == rsi_pkg::LED_RED)
        else $error("Unsuppressed missing port did not turn system red.");
    a_sup2_hidden: assert property (ctrl_ff.port2_report_suppress_switch
        && port2_missing_w && !port3_report_w && in_ff.feed_one_ok
        && in_ff.feed_two_ok && !in_ff.internal_err && !ring_blink_w
        |=> RELAY_CLOSED)
        else $error("Suppressed port two still opened relay.");
    a_sup3_hidden: assert property (ctrl_ff.port3_report_suppress_switch
        && port3_missing_w && !port2_report_w && in_ff.feed_one_ok
        && in_ff.feed_two_ok && !in_ff.internal_err && !ring_blink_w
        |=> SYSTEM_INDICATOR == rsi_pkg::LED_GREEN)
        else $error("Suppressed port three still turned system red.");
    a_blink_red: assert property (ring_blink_w && !power_lost_w
        && !in_ff.internal_err |=> SYSTEM_INDICATOR == rsi_pkg::LED_RED)
        else $error("Ring conflict did not turn system red.");
    a_feed_one: assert property (feed_one_low_w
        |=> SUPPLY_ONE_INDICATOR == rsi_pkg::LED_OFF && !RELAY_CLOSED)
        else $error("Low feed one not shown.");
    a_feed_two: assert property (in_ff.feed_two_ok
        |=> SUPPLY_TWO_INDICATOR == rsi_pkg::LED_GREEN)
        else $error("Good feed two not shown green.");
    a_ring_fault: assert property (ctrl_ff.redundancy_enable_switch
        && in_ff.ring_fault && !in_ff.ring_conflict
        |=> REDUNDANT_PORT_ACTIVE && RING_MANAGER_INDICATOR == rsi_pkg::LED_YELLOW)
        else $error("Ring fault did not activate redundant port.");
    a_ring_off: assert property (!ctrl_ff.redundancy_enable_switch
        |=> RING_MANAGER_INDICATOR == rsi_pkg::LED_OFF && !REDUNDANT_PORT_ACTIVE)
        else $error("Ring indicator lit with redundancy disabled.");
    a_blink_steady: assert property (ring_blink_w [*8]
        |=> !REDUNDANT_PORT_ACTIVE && RING_MANAGER_INDICATOR != rsi_pkg::LED_GREEN)
        else $error("Ring conflict showed green or active port.");
    a_port2_off: assert property (port2_missing_w
        |=> PORT2_ACTIVITY_INDICATOR == rsi_pkg::LED_OFF)
        else $error("Port two lamp lit without input.");
    a_port3_data: assert property (in_ff.port3_data
        |=> PORT3_ACTIVITY_INDICATOR == rsi_pkg::LED_YELLOW)
        else $error("Port three data not shown yellow.");
    a_apb_ready: assert property (setup_w |=> PREADY ##1 !PREADY)
        else $error("APB access did not complete in one access cycle.");

    c_all_healthy: cover property (RELAY_CLOSED [*3]);
    c_ring_blink:  cover property (ring_blink_w ##1 $fell(blink_on_ff));
    c_redport_on:  cover property ($rose(REDUNDANT_PORT_ACTIVE));
    c_ctrl_write:  cover property (access_w && PWRITE && hit_ctrl_w);

endmodule // rsi_status

// >>> rsi_alarm_monitor.sv
// Far-side alarm monitor wired across the fault relay contact.
`timescale 1ns/100ps
module rsi_alarm_monitor (
    input  wire logic clk,
    input  wire logic contact_closed,
    output logic      alarm_ff
);
    // An open contact breaks the monitoring loop and raises the alarm.
    // The loop is sampled on the clock because real monitors ignore glitches.
    always_ff @(posedge clk) begin
        alarm_ff <= (contact_closed !== 1'b1);
    end
endmodule // rsi_alarm_monitor

// >>> testbench.sv
// Self-checking testbench for the repeater status indicator logic.
`timescale 1ns/100ps
module testbench;
    localparam logic [1:0] K_OFF = rsi_pkg::LED_OFF;
    localparam logic [1:0] K_GRN = rsi_pkg::LED_GREEN;
    localparam logic [1:0] K_YEL = rsi_pkg::LED_YELLOW;
    localparam logic [1:0] K_RED = rsi_pkg::LED_RED;
    logic                ref_clk;
    logic                rst;
    logic                psel, penable, pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic                pready, pslverr, er, alarm;
    logic [1:0]          sys, sup1, sup2, ring, p1, p2, p3;
    logic                rport, relay;
    rsi_pkg::rsi_inputs_t ins;
    int                  failures = 0;
    int                  checks = 0;
    // Each entry is control bits then monitored inputs, feed one first.
    logic [13:0]         cs [16] = '{{3'h0, 11'h6A4}, {3'h0, 11'h4A4}, {3'h0, 11'h2A4},
        {3'h0, 11'h684}, {3'h2, 11'h684}, {3'h0, 11'h6A0}, {3'h4, 11'h6A0},
        {3'h1, 11'h6A4}, {3'h1, 11'h6A6}, {3'h1, 11'h6A5}, {3'h0, 11'h6A5},
        {3'h0, 11'h7A4}, {3'h0, 11'h0A4}, {3'h0, 11'h664}, {3'h0, 11'h6B4},
        {3'h6, 11'h280}};

    rsi_status #(.BLINK_HALF(4)) i_dut (
        .REF_CLK(ref_clk), .RESET(rst), .FEED_ONE_OK(ins.feed_one_ok),
        .FEED_TWO_OK(ins.feed_two_ok), .INTERNAL_ERR(ins.internal_err),
        .PORT1_DATA_CH1(ins.port1_data_ch1), .PORT1_DATA_CH2(ins.port1_data_ch2),
        .PORT2_POWER_OK(ins.port2_power_ok), .PORT2_DATA(ins.port2_data),
        .PORT3_POWER_OK(ins.port3_power_ok), .PORT3_DATA(ins.port3_data),
        .RING_FAULT(ins.ring_fault), .RING_CONFLICT(ins.ring_conflict),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SYSTEM_INDICATOR(sys), .SUPPLY_ONE_INDICATOR(sup1), .SUPPLY_TWO_INDICATOR(sup2),
        .RING_MANAGER_INDICATOR(ring), .PORT1_ACTIVITY_INDICATOR(p1),
        .PORT2_ACTIVITY_INDICATOR(p2), .PORT3_ACTIVITY_INDICATOR(p3),
        .REDUNDANT_PORT_ACTIVE(rport), .RELAY_CLOSED(relay));

    rsi_alarm_monitor i_mon (.clk(ref_clk), .contact_closed(relay), .alarm_ff(alarm));

    // Free-running reference clock.
    always #50 ref_clk = ~ref_clk;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("apb ready", 32'h1, 32'h0);
    endtask

    // Expected lamps, redundant port and relay; dead covers total power loss and internal error.
    function automatic logic [15:0] ref_out(rsi_pkg::rsi_inputs_t i, logic [2:0] c);
        logic m2, m3, cf, flt, dead;
        logic [1:0] sy, rg;
        m2 = !i.port2_power_ok && !i.port2_data && !c[1];
        m3 = !i.port3_power_ok && !i.port3_data && !c[2];
        cf = c[0] && i.ring_conflict;
        flt = (i.feed_one_ok ^ i.feed_two_ok) | m2 | m3 | cf;
        dead = !(i.feed_one_ok | i.feed_two_ok) | i.internal_err;
        sy = dead ? K_OFF : (flt ? K_RED : K_GRN);
        rg = !c[0] ? K_OFF : (i.ring_fault ? K_YEL : K_GRN);
        return {sy, i.feed_one_ok ? K_GRN : K_OFF, i.feed_two_ok ? K_GRN : K_OFF, rg,
                (i.port1_data_ch1 | i.port1_data_ch2) ? K_YEL : K_OFF,
                i.port2_data ? K_YEL : (i.port2_power_ok ? K_GRN : K_OFF),
                i.port3_data ? K_YEL : (i.port3_power_ok ? K_GRN : K_OFF),
                c[0] & i.ring_fault & !cf, !(flt | dead)};
    endfunction

    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog cuts a hang short well past the expected run length.
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        stop_test();
    end

    initial begin
        logic [15:0] e, m;
        logic        sy_y, sy_o, bad;
        logic [31:0] xi, xm;
        ref_clk = 1'b0; rst = 1'b1; ins = '0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = '0; pwdata = '0;
        repeat (12) @(posedge ref_clk);
        chk("reset outputs", 32'h0, {sys, sup1, sup2, ring, p1, p2, p3, rport, relay});
        rst <= 1'b0;
        apb(1'b0, rsi_pkg::ADDR_CTRL, 32'h0, rd, er);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0, rd, er);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, rsi_pkg::ADDR_INDICATORS, 32'hFFFFFFFF, rd, er);
        // Walk every table entry; a conflict with redundancy on leaves the ring lamp blinking.
        foreach (cs[k]) begin
            @(posedge ref_clk);
            ins <= cs[k][10:0];
            apb(1'b1, rsi_pkg::ADDR_CTRL, {29'h0, cs[k][13:11]}, rd, er);
            apb(1'b0, rsi_pkg::ADDR_CTRL, 32'h0, rd, er);
            chk("ctrl", {29'h0, cs[k][13:11]}, rd);
            repeat (4) @(posedge ref_clk);
            e = ref_out(cs[k][10:0], cs[k][13:11]);
            m = (cs[k][11] && cs[k][0]) ? 16'hFCFF : 16'hFFFF;
            chk("system lamp", e[15:14], sys);
            chk("supply lamps", e[13:10], {sup1, sup2});
            chk("ring lamp", e[9:8] & m[9:8], ring & m[9:8]);
            chk("port lamps", e[7:2], {p1, p2, p3});
            chk("port and relay", e[1:0], {rport, relay});
            chk("alarm", {31'h0, !e[0]}, {31'h0, alarm});
            apb(1'b1, rsi_pkg::ADDR_STATUS, 32'hFFFFFFFF, rd, er);
            apb(1'b0, rsi_pkg::ADDR_STATUS, 32'h0, rd, er);
            chk("status", {13'h0, e[1], (e[15:14] == K_RED), !e[0], 5'h0, cs[k][10:0]}, rd);
            chk("status err", 32'h0, {31'h0, er});
            // Indicator word: lamps in field order, blink flag above them.
            xi = {17'h0, !m[8], e[3:2], e[5:4], e[7:6], e[9:8], e[11:10], e[13:12], e[15:14]};
            xm = {24'hFFFFFF, m[9:8], 6'h3F};
            apb(1'b0, rsi_pkg::ADDR_INDICATORS, 32'h0, rd, er);
            chk("indicators", xi & xm, rd & xm);
            if (m[8] == 1'b0) begin
                sy_y = 1'b0; sy_o = 1'b0; bad = 1'b0;
                repeat (12) begin
                    @(posedge ref_clk);
                    sy_y |= (ring === K_YEL);
                    sy_o |= (ring === K_OFF);
                    bad |= (ring !== K_YEL && ring !== K_OFF);
                end
                chk("ring blink", 32'h1, {31'h0, sy_y & sy_o & !bad});
            end
        end
        stop_test();
    end
endmodule // testbench
